// ===== design/cis_pkg.sv
package cis_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses of aligned 32-bit words
   localparam logic [31:0] ADDR_SEL_HIGH = 32'h019C_0000;
   localparam logic [31:0] ADDR_SEL_LOW  = 32'h019C_0004;
   localparam logic [31:0] ADDR_STATUS   = 32'h019C_0008;
   localparam logic [31:0] ADDR_MASK     = 32'h019C_000C;

   ////////////////////////////////////////////////////////////////////////////
   // line layout
   localparam int unsigned NUM_LINES      = 16;
   localparam int unsigned FIRST_PROG     = 4;
   localparam int unsigned NUM_PROG       = 12;
   localparam int unsigned FIELDS_PER_REG = 6;
   localparam int unsigned CODE_W         = 5;
   localparam int unsigned NUM_SRC        = 32;
   localparam int unsigned LINE_RESET     = 0;
   localparam int unsigned LINE_NMI       = 1;
   localparam int unsigned LINE_RSVD_A    = 2;
   localparam int unsigned LINE_RSVD_B    = 3;
   localparam int unsigned FIELD_LSB [FIELDS_PER_REG] =
      '{0, 5, 10, 16, 21, 26};
   localparam logic [31:0] SEL_FIELD_MASK = 32'h7FFF_7FFF;

   ////////////////////////////////////////////////////////////////////////////
   // selector codes
   localparam logic [4:0] CODE_HOST_DSP   = 5'h00;
   localparam logic [4:0] CODE_TIMER0     = 5'h01;
   localparam logic [4:0] CODE_TIMER1     = 5'h02;
   localparam logic [4:0] CODE_SDRAM_A    = 5'h03;
   localparam logic [4:0] CODE_GPIO4      = 5'h04;
   localparam logic [4:0] CODE_GPIO5      = 5'h05;
   localparam logic [4:0] CODE_GPIO6      = 5'h06;
   localparam logic [4:0] CODE_GPIO7      = 5'h07;
   localparam logic [4:0] CODE_DMA        = 5'h08;
   localparam logic [4:0] CODE_DBG_DMA    = 5'h09;
   localparam logic [4:0] CODE_DBG_RX     = 5'h0A;
   localparam logic [4:0] CODE_DBG_TX     = 5'h0B;
   localparam logic [4:0] CODE_SER0_TX    = 5'h0C;
   localparam logic [4:0] CODE_SER0_RX    = 5'h0D;
   localparam logic [4:0] CODE_SER1_TX    = 5'h0E;
   localparam logic [4:0] CODE_SER1_RX    = 5'h0F;
   localparam logic [4:0] CODE_GPIO0      = 5'h10;
   localparam logic [4:0] CODE_SER2_TX    = 5'h11;
   localparam logic [4:0] CODE_SER2_RX    = 5'h12;
   localparam logic [4:0] CODE_TIMER2     = 5'h13;
   localparam logic [4:0] CODE_SDRAM_B    = 5'h14;
   localparam logic [4:0] CODE_RSVD_A     = 5'h15;
   localparam logic [4:0] CODE_RSVD_B     = 5'h16;
   localparam logic [4:0] CODE_CELL       = 5'h17;
   localparam logic [4:0] CODE_RSVD_LO    = 5'h18;
   localparam logic [4:0] CODE_RSVD_HI    = 5'h1D;
   localparam logic [4:0] CODE_VITERBI    = 5'h1E;
   localparam logic [4:0] CODE_TURBO      = 5'h1F;

   ////////////////////////////////////////////////////////////////////////////
   // reset values of the selector words
   localparam logic [31:0] SEL_LOW_RST  = {1'b0, CODE_DBG_DMA, CODE_DMA,
      CODE_GPIO7, 1'b0, CODE_GPIO6, CODE_GPIO5, CODE_GPIO4};
   localparam logic [31:0] SEL_HIGH_RST = {1'b0, CODE_TIMER1, CODE_TIMER0,
      CODE_HOST_DSP, 1'b0, CODE_DBG_TX, CODE_DBG_RX, CODE_SDRAM_A};

   ////////////////////////////////////////////////////////////////////////////
   // event status layout: bits 11:0 lines 4..15, bit 12 reserved code
   localparam int unsigned  STAT_W        = 13;
   localparam int unsigned  STAT_BAD_CODE = 12;
   localparam logic [12:0]  STAT_RST      = 13'h0000;

endpackage

// ===== design/cis_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cis_sel_if;
   logic [31:0] src_vec;
   logic [31:0] sel_low;
   logic [31:0] sel_high;
   logic [11:0] line_hit;
   modport top (output src_vec, output sel_low, output sel_high,
                input line_hit);
   modport mux (input src_vec, input sel_low, input sel_high,
                output line_hit);
endinterface
`default_nettype wire

// ===== design/cis_line_mux.sv
`timescale 1ns/1ps
`default_nettype none
module cis_line_mux
(
   cis_sel_if.mux sel_bus
);
   genvar i;
   generate
      for (i = 0; i < cis_pkg::NUM_PROG; i++)
      begin : g_line
         localparam int unsigned LSB =
            cis_pkg::FIELD_LSB[i % cis_pkg::FIELDS_PER_REG];
         wire logic [31:0] word;
         wire logic [4:0]  code;
         assign word = (i < cis_pkg::FIELDS_PER_REG) ?
                       sel_bus.sel_low : sel_bus.sel_high;
         assign code = word[LSB +: cis_pkg::CODE_W];
         assign sel_bus.line_hit[i] = sel_bus.src_vec[code];
      end
   endgenerate
endmodule
`default_nettype wire

// ===== design/cis_top.sv
// Function
// - sixteen CPU lines, line 0 highest priority, line 15 lowest.
// - lines 0-3 fixed: reset, nmi, two reserved lines held low.
// - lines 4-15 maskable, each fed by a 5-bit selector field.
// - high selector word at 019C0000, low selector word at 019C0004.
// - low word fields for lines 4-9; bits 15 and 31 unused.
// - high word fields for lines 10-15 at the same positions.
// - lines 4-7 reset to gpio pin events 4-7.
// - line 8 resets to dma completion, line 9 to debug dma.
// - line 10 sdram refresh A, lines 11-12 debug exchange rx/tx.
// - line 13 host event, 14 timer zero, 15 timer one.
// - codes 0C-0F and 11-12 select serial port events.
// - code 10 gpio zero, 13 timer two, 14 sdram refresh B.
// - code 17 cell interface, 1E viterbi, 1F turbo coprocessor.
`timescale 1ns/1ps
`default_nettype none
module cis_top
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [31:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [31:0] reg_rdata,
   input  wire logic        reset_request,
   input  wire logic        nmi_request,
   input  wire logic        host_dsp_event,
   input  wire logic        timer_zero_event,
   input  wire logic        timer_one_event,
   input  wire logic        timer_two_event,
   input  wire logic        sdram_refresh_event_first,
   input  wire logic        sdram_refresh_event_second,
   input  wire logic [3:0]  gpio_pin_event_four,
   input  wire logic        dma_completion_event,
   input  wire logic        debug_dma_event,
   input  wire logic        debug_exchange_rx_event,
   input  wire logic        debug_exchange_tx_event,
   input  wire logic        serial0_tx_event,
   input  wire logic        serial0_rx_event,
   input  wire logic        serial1_tx_event,
   input  wire logic        serial1_rx_event,
   input  wire logic        serial2_tx_event,
   input  wire logic        serial2_rx_event,
   input  wire logic        gpio_event_zero,
   input  wire logic        cell_interface_event,
   input  wire logic        viterbi_coproc_event,
   input  wire logic        turbo_coproc_event,
   output var  logic [15:0] cpu_int,
   output var  logic        irq
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [31:0]                  sel_low_reg;
   logic [31:0]                  sel_low_next;
   logic [31:0]                  sel_high_reg;
   logic [31:0]                  sel_high_next;
   logic [cis_pkg::STAT_W-1:0]   status_reg;
   logic [cis_pkg::STAT_W-1:0]   status_next;
   logic [cis_pkg::STAT_W-1:0]   mask_reg;
   logic [cis_pkg::STAT_W-1:0]   mask_next;
   logic [15:0]                  cpu_int_reg;
   logic [15:0]                  cpu_int_next;
   logic [31:0]                  rdata_reg;
   logic [31:0]                  rdata_next;
   logic [3:0]                   pin_meta_reg;
   logic [3:0]                   pin_sync_reg;

   cis_sel_if sel_bus ();

   cis_line_mux u_mux
   (
      .sel_bus (sel_bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // reserved code detection

   function automatic logic code_reserved(input logic [4:0] c);
      code_reserved = (c == cis_pkg::CODE_RSVD_A) ||
                      (c == cis_pkg::CODE_RSVD_B) ||
                      ((c >= cis_pkg::CODE_RSVD_LO) &&
                       (c <= cis_pkg::CODE_RSVD_HI));
   endfunction

   function automatic logic word_reserved(input logic [31:0] w);
      logic hit;
      hit = 1'b0;
      for (int f = 0; f < cis_pkg::FIELDS_PER_REG; f++)
      begin
         hit = hit | code_reserved(w[cis_pkg::FIELD_LSB[f] +:
                                     cis_pkg::CODE_W]);
      end
      word_reserved = hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   wire logic hit_high;
   wire logic hit_low;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic wr_high;
   wire logic wr_low;
   wire logic wr_status;
   wire logic wr_mask;
   wire logic bad_code_wr;

   assign hit_high   = (reg_addr == cis_pkg::ADDR_SEL_HIGH);
   assign hit_low    = (reg_addr == cis_pkg::ADDR_SEL_LOW);
   assign hit_status = (reg_addr == cis_pkg::ADDR_STATUS);
   assign hit_mask   = (reg_addr == cis_pkg::ADDR_MASK);
   assign wr_high    = reg_wr && hit_high;
   assign wr_low     = reg_wr && hit_low;
   assign wr_status  = reg_wr && hit_status;
   assign wr_mask    = reg_wr && hit_mask;
   assign bad_code_wr = (wr_high || wr_low) && word_reserved(reg_wdata);

   ////////////////////////////////////////////////////////////////////////////
   // event source vector, indexed by selector code

   logic [31:0] src_vec;

   always_comb
   begin
      src_vec = 32'h0000_0000;
      src_vec[cis_pkg::CODE_HOST_DSP] = host_dsp_event;
      src_vec[cis_pkg::CODE_TIMER0]   = timer_zero_event;
      src_vec[cis_pkg::CODE_TIMER1]   = timer_one_event;
      src_vec[cis_pkg::CODE_SDRAM_A]  = sdram_refresh_event_first;
      src_vec[cis_pkg::CODE_GPIO4]    = pin_sync_reg[0];
      src_vec[cis_pkg::CODE_GPIO5]    = pin_sync_reg[1];
      src_vec[cis_pkg::CODE_GPIO6]    = pin_sync_reg[2];
      src_vec[cis_pkg::CODE_GPIO7]    = pin_sync_reg[3];
      src_vec[cis_pkg::CODE_DMA]      = dma_completion_event;
      src_vec[cis_pkg::CODE_DBG_DMA]  = debug_dma_event;
      src_vec[cis_pkg::CODE_DBG_RX]   = debug_exchange_rx_event;
      src_vec[cis_pkg::CODE_DBG_TX]   = debug_exchange_tx_event;
      src_vec[cis_pkg::CODE_SER0_TX]  = serial0_tx_event;
      src_vec[cis_pkg::CODE_SER0_RX]  = serial0_rx_event;
      src_vec[cis_pkg::CODE_SER1_TX]  = serial1_tx_event;
      src_vec[cis_pkg::CODE_SER1_RX]  = serial1_rx_event;
      src_vec[cis_pkg::CODE_SER2_TX]  = serial2_tx_event;
      src_vec[cis_pkg::CODE_SER2_RX]  = serial2_rx_event;
      // gpio zero, timer two, sdram B
      src_vec[cis_pkg::CODE_GPIO0]    = gpio_event_zero;
      src_vec[cis_pkg::CODE_TIMER2]   = timer_two_event;
      src_vec[cis_pkg::CODE_SDRAM_B]  = sdram_refresh_event_second;
      src_vec[cis_pkg::CODE_CELL]     = cell_interface_event;
      src_vec[cis_pkg::CODE_VITERBI]  = viterbi_coproc_event;
      src_vec[cis_pkg::CODE_TURBO]    = turbo_coproc_event;
   end

   assign sel_bus.src_vec  = src_vec;
   assign sel_bus.sel_low  = sel_low_reg;
   assign sel_bus.sel_high = sel_high_reg;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic

   // low word keeps bits 15 and 31 zero
   assign sel_low_next  = wr_low ? (reg_wdata & cis_pkg::SEL_FIELD_MASK)
                                 : sel_low_reg;
   assign sel_high_next = wr_high ? (reg_wdata & cis_pkg::SEL_FIELD_MASK)
                                  : sel_high_reg;
   assign mask_next     = wr_mask ? reg_wdata[cis_pkg::STAT_W-1:0]
                                  : mask_reg;

   wire logic [cis_pkg::STAT_W-1:0] stat_set;
   wire logic [cis_pkg::STAT_W-1:0] stat_clr;

   assign stat_set = {bad_code_wr, sel_bus.line_hit};
   assign stat_clr = wr_status ? reg_wdata[cis_pkg::STAT_W-1:0]
                               : {cis_pkg::STAT_W{1'b0}};
   // set wins over a same-cycle clear
   assign status_next = (status_reg & ~stat_clr) | stat_set;

   assign cpu_int_next = {sel_bus.line_hit, 1'b0, 1'b0, nmi_request,
                          reset_request};

   wire logic [31:0] rd_value;

   assign rd_value =
      hit_high   ? sel_high_reg :
      hit_low    ? sel_low_reg :
      hit_status ? {{(32-cis_pkg::STAT_W){1'b0}}, status_reg} :
      hit_mask   ? {{(32-cis_pkg::STAT_W){1'b0}}, mask_reg} :
                   32'h0000_0000;
   assign rdata_next = reg_rd ? rd_value : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // flip-flops

   always_ff @(posedge clk)
   begin
      pin_meta_reg <= gpio_pin_event_four;
      pin_sync_reg <= pin_meta_reg;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sel_low_reg  <= cis_pkg::SEL_LOW_RST;
         sel_high_reg <= cis_pkg::SEL_HIGH_RST;
         status_reg   <= cis_pkg::STAT_RST;
         mask_reg     <= cis_pkg::STAT_RST;
         cpu_int_reg  <= 16'h0000;
         rdata_reg    <= 32'h0000_0000;
      end
      else
      begin
         sel_low_reg  <= sel_low_next;
         sel_high_reg <= sel_high_next;
         status_reg   <= status_next;
         mask_reg     <= mask_next;
         cpu_int_reg  <= cpu_int_next;
         rdata_reg    <= rdata_next;
      end
   end

   assign cpu_int   = cpu_int_reg;
   assign reg_rdata = rdata_reg;
   assign irq       = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_RSVD_LINES_LOW:
   assert property (@(posedge clk) disable iff (sys_rst)
      cpu_int[cis_pkg::LINE_RSVD_B:cis_pkg::LINE_RSVD_A] == 2'b00)
   else $error("reserved cpu lines not low");

   AST_FIXED_NMI:
   assert property (@(posedge clk) disable iff (sys_rst)
      ##1 cpu_int[cis_pkg::LINE_NMI] == $past(nmi_request) &&
          cpu_int[cis_pkg::LINE_RESET] == $past(reset_request))
   else $error("fixed lines do not follow reset and nmi requests");

   AST_LOW_DEFAULT:
   assert property (@(posedge clk)
      sys_rst |=> sel_low_reg == cis_pkg::SEL_LOW_RST)
   else $error("low selector word wrong after reset");

   AST_HIGH_DEFAULT:
   assert property (@(posedge clk)
      sys_rst |=> sel_high_reg == cis_pkg::SEL_HIGH_RST)
   else $error("high selector word wrong after reset");

   AST_UNUSED_BITS:
   assert property (@(posedge clk) disable iff (sys_rst)
      !sel_low_reg[15] && !sel_low_reg[31] && !sel_high_reg[15] &&
      !sel_high_reg[31])
   else $error("unused selector bits set");

   AST_WRITE_HIGH:
   assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && (reg_addr == cis_pkg::ADDR_SEL_HIGH) |=>
      sel_high_reg == ($past(reg_wdata) & cis_pkg::SEL_FIELD_MASK))
   else $error("high selector write not stored");

   AST_READ_LOW:
   assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && (reg_addr == cis_pkg::ADDR_SEL_LOW) |=>
      reg_rdata == $past(sel_low_reg) ##1 reg_rdata == 32'h0000_0000 ||
      $past(reg_rd))
   else $error("low selector read data wrong");

   AST_LINE14_FOLLOWS:
   assert property (@(posedge clk) disable iff (sys_rst)
      ##1 cpu_int[14] == $past(src_vec[sel_high_reg[25:21]]))
   else $error("line 14 not fed by its selected source");

   AST_LINE4_GPIO0:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_low_reg[4:0] == cis_pkg::CODE_GPIO0 && gpio_event_zero
      |=> cpu_int[4])
   else $error("gpio zero not routed to line 4");

   AST_LINE8_DMA:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_low_reg[25:21] == cis_pkg::CODE_DMA |->
      ##1 cpu_int[8] == $past(dma_completion_event))
   else $error("dma completion not routed to line 8");

   AST_STATUS_STICKY:
   assert property (@(posedge clk) disable iff (sys_rst)
      cpu_int_next[15] |=> status_reg[11] [*2] or
      (status_reg[11] ##1 $past(wr_status)))
   else $error("line 15 event not held in status");

   AST_WRITE_LOW:
   assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && (reg_addr == cis_pkg::ADDR_SEL_LOW) |=>
      sel_low_reg == ($past(reg_wdata) & cis_pkg::SEL_FIELD_MASK))
   else $error("low selector write not stored");

   AST_RDATA_IDLE:
   assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
   else $error("read data not zero outside a read");

   AST_LINE10_SDRAM:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_high_reg[cis_pkg::FIELD_LSB[0] +: cis_pkg::CODE_W] ==
      cis_pkg::CODE_SDRAM_A |->
      ##1 cpu_int[10] == $past(sdram_refresh_event_first))
   else $error("sdram refresh A not routed to line 10");

   AST_LINE11_SER0:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_high_reg[cis_pkg::FIELD_LSB[1] +: cis_pkg::CODE_W] ==
      cis_pkg::CODE_SER0_TX |->
      ##1 cpu_int[11] == $past(serial0_tx_event))
   else $error("serial 0 transmit not routed to line 11");

   AST_LINE13_HOST:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_high_reg[cis_pkg::FIELD_LSB[3] +: cis_pkg::CODE_W] ==
      cis_pkg::CODE_HOST_DSP |->
      ##1 cpu_int[13] == $past(host_dsp_event))
   else $error("host event not routed to line 13");

   AST_LINE15_TURBO:
   assert property (@(posedge clk) disable iff (sys_rst)
      sel_high_reg[cis_pkg::FIELD_LSB[5] +: cis_pkg::CODE_W] ==
      cis_pkg::CODE_TURBO |->
      ##1 cpu_int[15] == $past(turbo_coproc_event))
   else $error("turbo coprocessor not routed to line 15");

   AST_STATUS_CLEAR:
   assert property (@(posedge clk) disable iff (sys_rst)
      wr_status && reg_wdata[0] && !sel_bus.line_hit[0] |=>
      !status_reg[0])
   else $error("status bit not cleared by a written one");

endmodule
`default_nettype wire

// ===== tb/cis_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module cis_src_model
(
   input  wire logic [31:0] src,
   output wire logic [31:0] evt
);
   // reserved codes have no peripheral behind them
   localparam logic [31:0] NO_SRC = 32'h3F60_0000;
   assign evt = src & ~NO_SRC;
endmodule
`default_nettype wire

// ===== tb/test_cpu_interrupt_selector.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_interrupt_selector;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [31:0] reg_addr = 32'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [31:0] src = 32'h0;
   logic [1:0]  fixed_req = 2'h0;
   logic        run = 1'b0;
   logic        live = 1'b0;
   logic [31:0] evt;
   logic [15:0] cpu_int;
   logic        irq;
   integer      seed = 32'hdf40;
   integer      err_total = 0;
   integer      num_checks = 0;
   int          lsb [6] = '{0, 5, 10, 16, 21, 26};
   logic [31:0] sel_lo_m;
   logic [31:0] sel_hi_m;
   logic [31:0] exp_rd = 32'h0;
   logic [12:0] stat_m = 13'h0;
   logic [12:0] mask_m = 13'h0;
   logic [15:0] exp_int = 16'h0;
   logic [3:0]  gq [$] = '{4'h0, 4'h0};

   always #5 clk = ~clk;

   cis_src_model i_cis_src_model (.src(src), .evt(evt));

   cis_top i_cis_top
   (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reset_request(fixed_req[0]),
      .nmi_request(fixed_req[1]), .host_dsp_event(evt[0]),
      .timer_zero_event(evt[1]), .timer_one_event(evt[2]),
      .timer_two_event(evt[19]), .sdram_refresh_event_first(evt[3]),
      .sdram_refresh_event_second(evt[20]),
      .gpio_pin_event_four(evt[7:4]), .dma_completion_event(evt[8]),
      .debug_dma_event(evt[9]), .debug_exchange_rx_event(evt[10]),
      .debug_exchange_tx_event(evt[11]), .serial0_tx_event(evt[12]),
      .serial0_rx_event(evt[13]), .serial1_tx_event(evt[14]),
      .serial1_rx_event(evt[15]), .serial2_tx_event(evt[17]),
      .serial2_rx_event(evt[18]), .gpio_event_zero(evt[16]),
      .cell_interface_event(evt[23]), .viterbi_coproc_event(evt[30]),
      .turbo_coproc_event(evt[31]), .cpu_int(cpu_int), .irq(irq)
   );

   function automatic logic rsvd(input logic [4:0] c);
      return c == 5'h15 || c == 5'h16 || (c >= 5'h18 && c <= 5'h1D);
   endfunction

   // software side never programs a reserved code
   function automatic logic [4:0] legal(input logic [4:0] c);
      return rsvd(c) ? (c ^ 5'h10) : c;
   endfunction

   function automatic logic line_val(input logic [4:0] c,
                                     input logic [3:0] g,
                                     input logic [31:0] s);
      if (rsvd(c))
         return 1'b0;
      if (c >= 5'h04 && c <= 5'h07)
         return g[c[1:0]];
      return s[c];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // behavioural model, updated at each rising edge
   always @(posedge clk)
   begin : model
      logic [3:0]  g;
      logic [31:0] w;
      logic [12:0] set;
      logic [12:0] clr;
      integer      k;
      g = gq.pop_front();
      gq.push_back(src[7:4]);
      live = 1'b1;
      set = 13'h0;
      clr = 13'h0;
      exp_rd = 32'h0;
      if (sys_rst)
      begin
         sel_lo_m = 32'h2507_18A4;
         sel_hi_m = 32'h0820_2D43;
         stat_m = 13'h0;
         mask_m = 13'h0;
         exp_int = 16'h0;
      end
      else
      begin
         exp_int[3:0] = {2'b00, fixed_req};
         for (k = 4; k < 16; k++)
         begin
            w = (k < 10) ? sel_lo_m : sel_hi_m;
            exp_int[k] = line_val(w[lsb[(k - 4) % 6] +: 5], g, src);
         end
         set[11:0] = exp_int[15:4];
         if (reg_rd)
         begin
            case (reg_addr)
               cis_pkg::ADDR_SEL_LOW: exp_rd = sel_lo_m;
               cis_pkg::ADDR_SEL_HIGH: exp_rd = sel_hi_m;
               cis_pkg::ADDR_STATUS: exp_rd = {19'h0, stat_m};
               cis_pkg::ADDR_MASK: exp_rd = {19'h0, mask_m};
               default: exp_rd = 32'h0;
            endcase
         end
         if (reg_wr)
         begin
            // selector words, bits 15 and 31 dropped
            w = reg_wdata & 32'h7FFF_7FFF;
            case (reg_addr)
               cis_pkg::ADDR_SEL_LOW: sel_lo_m = w;
               cis_pkg::ADDR_SEL_HIGH: sel_hi_m = w;
               cis_pkg::ADDR_STATUS: clr = reg_wdata[12:0];
               cis_pkg::ADDR_MASK: mask_m = reg_wdata[12:0];
               default: ;
            endcase
            for (k = 0; k < 6; k++)
               if ((reg_addr === cis_pkg::ADDR_SEL_LOW ||
                    reg_addr === cis_pkg::ADDR_SEL_HIGH) &&
                   rsvd(w[lsb[k] +: 5]))
                  set[12] = 1'b1;
         end
         stat_m = (stat_m & ~clr) | set;
      end
   end

   task automatic chk_vec(input string n, input logic [31:0] e,
                          input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic s);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value %s expected %b seen %b", n, e, s);
      end
   endtask

   always @(negedge clk)
      if (live)
      begin
         chk_vec("cpu_int", {16'h0, exp_int}, {16'h0, cpu_int});
         chk_vec("reg_rdata", exp_rd, reg_rdata);
         chk_bit("irq", |(stat_m & mask_m), irq);
      end

   ////////////////////////////////////////////////////////////////////////////
   // stimulus
   always @(posedge clk)
   begin
      src <= run ? 32'($random(seed)) : 32'h0;
      fixed_req <= run ? 2'($random(seed)) : 2'h0;
   end

   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask

   task automatic bus_rd(input logic [31:0] a);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      @(posedge clk);
   endtask

   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic read_all();
      bus_rd(cis_pkg::ADDR_SEL_LOW);
      bus_rd(cis_pkg::ADDR_SEL_HIGH);
      bus_rd(32'h019C_0010);
      bus_rd(cis_pkg::ADDR_STATUS);
      bus_rd(cis_pkg::ADDR_MASK);
      repeat (30) idle();
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin : main
      integer      c;
      integer      k;
      logic [31:0] lo;
      logic [31:0] hi;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) idle();
      run <= 1'b1;
      read_all();
      // every legal code on every line
      for (c = 0; c < 32; c++)
      begin
         lo = $random(seed);
         hi = $random(seed);
         for (k = 0; k < 6; k++)
         begin
            lo[lsb[k] +: 5] = legal(5'(c + k));
            hi[lsb[k] +: 5] = legal(5'(c + k + 6));
         end
         bus_wr(cis_pkg::ADDR_SEL_LOW, lo);
         bus_wr(cis_pkg::ADDR_SEL_HIGH, hi);
         bus_rd(cis_pkg::ADDR_SEL_LOW);
         bus_rd(cis_pkg::ADDR_SEL_HIGH);
         repeat (6) idle();
      end
      for (k = 0; k < 12; k++)
      begin
         bus_wr(cis_pkg::ADDR_MASK, $random(seed));
         repeat (3) idle();
         bus_rd(cis_pkg::ADDR_STATUS);
         bus_wr(cis_pkg::ADDR_STATUS, $random(seed));
         bus_rd(cis_pkg::ADDR_STATUS);
         bus_rd(cis_pkg::ADDR_MASK);
      end
      run <= 1'b0;
      repeat (4) idle();
      sys_rst <= 1'b1;
      repeat (3) idle();
      sys_rst <= 1'b0;
      repeat (2) idle();
      run <= 1'b1;
      read_all();
      final_report();
   end
endmodule
`default_nettype wire
